// File: core/fss_sequencer.sv
// The Wishbone interface to the registers and the placing of the registers were chosen for this implementation.
`timescale 1ns/10ps
// Functional notes
// - During configuration unused I/Os float with internal pull-up enabled.
// - During configuration hold cell flip-flops set/reset, float internal bidir buffers.
// - Combinational logic works as soon as its configuration is written.
// - Start-up begins when clock count equals length and end frame seen.
// - Done, flip-flop release and I/O activation order is programmable.
// - Four start-up modes; user-clock modes time events from user clock.
// - Synced modes: release follows done line rise plus selected clock edges.
// - Free modes: release counts start-up clock edges, done line ignored.
// - Done pin is open drain with default-on optional pull-up.
// - Default synced config-clock mode releases done on first clock edge.
// - Outside party holding done low withholds release in synced mode.
// - Each release is immediate or one to four edges after done high.
// - By default both releases follow done high immediately.
// - Low program pulse clears memory, floats I/Os, samples modes, reconfigures.
// - After reconfiguration the done output is released.
// - Stored option skips configuration memory clear on reconfiguration.
// - Option keeps logic running during partial reconfiguration.
// - Stored options disable set/reset, I/O floating, RAM clear next time.
// - Modes sampled and configuration entered after init high two cycles.
// - In start-up or operation reset is ignored; only program restarts.
module fss_sequencer
   import fss_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire fss_wb_req_s wb_req,
   output logic             wb_ack,
   output logic [31:0]      wb_rdata,
   input  wire logic        config_clock,
   input  wire logic        user_startup_clock,
   input  wire logic        init_in,
   input  wire logic        program_request_n,
   input  wire logic        cfg_reset_n,
   input  wire logic [3:0]  mode_sel,
   input  wire logic        eoc_frame_written,
   input  wire logic        done_in,
   output logic             done_out,
   output logic             done_oe,
   output logic             done_pullup_en,
   output logic             io_hiz,
   output logic             io_pullup_en,
   output logic             logic_cell_hold,
   output logic             internal_bidir_hiz,
   output logic             comb_logic_live,
   output logic             cfg_mem_clear,
   output logic             user_ram_clear,
   output logic             startup_done
);

   typedef struct packed {
      logic [NPIN-1:0] meta;
      logic [NPIN-1:0] sync;
      logic            config_clock_prev;
      logic            user_startup_clock_prev;
      fss_state_e      st;
      logic [31:0]     ctrl;
      logic [31:0]     len;
      fss_opt_s        opt;
      logic [3:0]      mode;
      logic [3:0]      mode_meta;
      logic [3:0]      mode_sync;
      logic [1:0]      init_cnt;
      logic [23:0]     ccnt;
      logic            eoc;
      logic [3:0]      scnt;
      logic [3:0]      dcnt;
      logic            done_hi;
      logic            done_rel;
      logic            ff_rel;
      logic            io_act;
      logic            done_oe;
      logic            io_hiz;
      logic            io_pull;
      logic            lc_hold;
      logic            bidir_hiz;
      logic            comb_live;
      logic            oper;
      logic            mem_clear;
      logic            ram_clear;
      logic            ack;
      logic [31:0]     rdat;
   } fss_regs_s;

   fss_regs_s q;
   fss_regs_s n;
   logic      rst_meta;
   logic      rst_n;

   function automatic logic [3:0] clamp_delay(input logic [2:0] f);
      clamp_delay = (f > MAX_DELAY) ? {1'b0, MAX_DELAY} : {1'b0, f};
   endfunction

   // ------------------------------------------------------------
   // Reset release
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // ------------------------------------------------------------
   // Decoded controls
   // ------------------------------------------------------------
   logic       is_sync;
   logic       config_clock_rise;
   logic       st_edge;
   logic [3:0] done_dly;
   logic [3:0] ff_dly;
   logic [3:0] io_dly;
   logic       gsr_force;
   logic       ioz_force;
   logic       bus_acc;

   always_comb
   begin
      is_sync   = q.ctrl[CT_MODE];
      config_clock_rise = q.sync[PIN_CONFIG_CLOCK] & ~q.config_clock_prev;
      st_edge   = q.ctrl[CT_MODE+1] ? (q.sync[PIN_USER_STARTUP_CLOCK] & ~q.user_startup_clock_prev) : config_clock_rise;
      done_dly  = {1'b0, q.ctrl[CT_DONE +: 3]};
      ff_dly    = clamp_delay(q.ctrl[CT_FF +: 3]);
      io_dly    = clamp_delay(q.ctrl[CT_IO +: 3]);
      gsr_force = ~q.opt.no_gsr & ~q.opt.keep_running;
      ioz_force = ~q.opt.no_ioz & ~q.opt.keep_running;
      bus_acc   = wb_req.cyc & wb_req.stb & ~q.ack;
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb
   begin
      n           = q;
      n.meta      = {cfg_reset_n, program_request_n, init_in, done_in,
                     user_startup_clock, config_clock};
      n.sync      = q.meta;
      n.config_clock_prev = q.sync[PIN_CONFIG_CLOCK];
      n.user_startup_clock_prev = q.sync[PIN_USER_STARTUP_CLOCK];
      n.mode_meta = mode_sel;
      n.mode_sync = q.mode_meta;
      n.mem_clear = 1'b0;
      n.ram_clear = 1'b0;

      case (q.st)
         ST_INIT:
         begin
            n.init_cnt = !q.sync[PIN_INIT] ? 2'h0 :
                         (q.init_cnt == INIT_HIGH) ? q.init_cnt : q.init_cnt + 2'h1;
            if (q.init_cnt == INIT_HIGH && q.sync[PIN_INIT] &&
                q.sync[PIN_PROG] && q.sync[PIN_RST])
            begin
               n.mode = q.mode_sync;
               n.st   = ST_CONFIG;
               n.ccnt = 24'h0;
               n.eoc  = 1'b0;
            end
         end
         ST_CONFIG:
         begin
            if (config_clock_rise)
               n.ccnt = q.ccnt + 24'h1;
            n.eoc = q.eoc | eoc_frame_written;
            if (!q.sync[PIN_PROG] || !q.sync[PIN_RST])
               n.st = ST_INIT;
            else if (q.ccnt == q.len[23:0] && q.eoc)
            begin
               n.st       = ST_STARTUP;
               n.scnt     = 4'h0;
               n.dcnt     = 4'h0;
               n.done_hi  = 1'b0;
               n.done_rel = 1'b0;
               n.ff_rel   = 1'b0;
               n.io_act   = 1'b0;
               n.opt      = '{skip_clear:   q.ctrl[CT_SKIP],
                              keep_running: q.ctrl[CT_KEEP],
                              no_gsr:       q.ctrl[CT_NOGSR],
                              no_ioz:       q.ctrl[CT_NOIOZ],
                              no_ram_clear: q.ctrl[CT_NORAM]};
            end
         end
         ST_STARTUP:
         begin
            if (st_edge)
            begin
               if (q.scnt != CNT_SAT)
                  n.scnt = q.scnt + 4'h1;
               // Line is only trusted once our own done is off it
               n.done_hi = q.sync[PIN_DONE] & q.done_rel;
               if (q.done_hi && q.dcnt != CNT_SAT)
                  n.dcnt = q.dcnt + 4'h1;
            end
            n.done_rel = q.done_rel | (n.scnt >= done_dly);
            if (is_sync)
            begin
               n.ff_rel = q.ff_rel | (q.done_hi & (q.dcnt >= ff_dly));
               n.io_act = q.io_act | (q.done_hi & (q.dcnt >= io_dly));
            end
            else
            begin
               n.ff_rel = q.ff_rel | (q.scnt >= ff_dly);
               n.io_act = q.io_act | (q.scnt >= io_dly);
            end
            if (q.done_rel && q.ff_rel && q.io_act)
               n.st = ST_OPERATE;
            if (!q.sync[PIN_PROG])
               n.st = ST_CLEAR;
         end
         ST_OPERATE:
         begin
            if (!q.sync[PIN_PROG])
               n.st = ST_CLEAR;
         end
         ST_CLEAR:
         begin
            n.mem_clear = ~q.opt.skip_clear;
            n.ram_clear = ~q.opt.no_ram_clear;
            n.init_cnt  = 2'h0;
            n.st        = ST_INIT;
         end
         default:
         begin
            n.st = ST_INIT;
         end
      endcase

      n.oper = (n.st == ST_OPERATE);

      // Pin and cell controls follow the state being entered
      case (n.st)
         ST_STARTUP:
         begin
            n.done_oe   = ~n.done_rel;
            n.io_hiz    = ~n.io_act;
            n.io_pull   = ~n.io_act;
            n.lc_hold   = ~n.ff_rel;
            n.bidir_hiz = ~n.ff_rel;
            n.comb_live = 1'b1;
         end
         ST_OPERATE:
         begin
            n.done_oe   = 1'b0;
            n.io_hiz    = 1'b0;
            n.io_pull   = 1'b0;
            n.lc_hold   = 1'b0;
            n.bidir_hiz = 1'b0;
            n.comb_live = 1'b1;
         end
         default:
         begin
            n.done_oe   = 1'b1;
            n.io_hiz    = ioz_force;
            n.io_pull   = ioz_force;
            n.lc_hold   = gsr_force;
            n.bidir_hiz = gsr_force;
            n.comb_live = (n.st == ST_CONFIG) | q.opt.keep_running;
         end
      endcase

      // Wishbone classic slave, one wait state, unmapped reads zero
      n.ack = bus_acc;
      // Write lands on the edge at which the master samples ack
      if (wb_req.cyc && wb_req.stb && wb_req.we && q.ack)
      begin
         for (int i = 0; i < 4; i++)
         begin
            if (wb_req.sel[i] && wb_req.adr == ADR_CTRL)
               n.ctrl[8*i +: 8] = wb_req.dat[8*i +: 8];
            if (wb_req.sel[i] && wb_req.adr == ADR_LENGTH)
               n.len[8*i +: 8] = wb_req.dat[8*i +: 8];
         end
         n.ctrl = n.ctrl & CTRL_MASK;
         n.len  = n.len & LEN_MASK;
      end
      case (wb_req.adr)
         ADR_CTRL:   n.rdat = q.ctrl;
         ADR_LENGTH: n.rdat = q.len;
         ADR_STATUS: n.rdat = {10'h0, q.opt, q.mode, q.sync[PIN_DONE], q.eoc, q.io_act,
                               q.ff_rel, q.done_rel, 5'h0, q.st};
         default:    n.rdat = 32'h0;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         q           <= '0;
         q.ctrl      <= CTRL_RST;
         q.len       <= LEN_RST;
         q.done_oe   <= 1'b1;
         q.io_hiz    <= 1'b1;
         q.io_pull   <= 1'b1;
         q.lc_hold   <= 1'b1;
         q.bidir_hiz <= 1'b1;
      end
      else
         q <= n;
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign wb_ack             = q.ack;
   assign wb_rdata           = q.rdat;
   assign done_out           = 1'b0;
   assign done_oe            = q.done_oe;
   assign done_pullup_en     = q.ctrl[CT_PULLUP];
   assign io_hiz             = q.io_hiz;
   assign io_pullup_en       = q.io_pull;
   assign logic_cell_hold    = q.lc_hold;
   assign internal_bidir_hiz = q.bidir_hiz;
   assign comb_logic_live    = q.comb_live;
   assign cfg_mem_clear      = q.mem_clear;
   assign user_ram_clear     = q.ram_clear;
   assign startup_done       = q.oper;

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_cfg_float;
      q.st == ST_CONFIG && ioz_force |-> q.io_hiz && q.io_pull;
   endproperty
   a_cfg_float: assert property (p_cfg_float) else $error("io not floated");

   property p_cfg_hold;
      q.st == ST_CONFIG && gsr_force |-> q.lc_hold && q.bidir_hiz && q.comb_live;
   endproperty
   a_cfg_hold: assert property (p_cfg_hold) else $error("cells not held");

   property p_start_cond;
      $rose(q.st == ST_STARTUP) |-> $past(q.ccnt == q.len[23:0] && q.eoc);
   endproperty
   a_start_cond: assert property (p_start_cond) else $error("early start-up");

   property p_done_first;
      q.st == ST_STARTUP && !q.done_rel && st_edge && done_dly == 4'h1 && q.sync[PIN_PROG]
         |=> !q.done_oe;
   endproperty
   a_done_first: assert property (p_done_first) else $error("done late");

   property p_hold_low;
      q.st == ST_STARTUP && is_sync && !q.done_hi && !q.ff_rel |=> !q.ff_rel;
   endproperty
   a_hold_low: assert property (p_hold_low) else $error("released on low done");

   property p_sync_rel;
      q.st == ST_STARTUP && is_sync && q.done_hi && q.dcnt >= io_dly |=> q.io_act;
   endproperty
   a_sync_rel: assert property (p_sync_rel) else $error("io not activated");

   property p_free_rel;
      q.st == ST_STARTUP && !is_sync && q.scnt >= ff_dly |=> q.ff_rel;
   endproperty
   a_free_rel: assert property (p_free_rel) else $error("ff not released");

   property p_init_two;
      $rose(q.st == ST_CONFIG) |-> $past(q.init_cnt) == INIT_HIGH;
   endproperty
   a_init_two: assert property (p_init_two) else $error("init too short");

   property p_reset_ign;
      q.st == ST_OPERATE && q.sync[PIN_PROG] |=> q.st == ST_OPERATE;
   endproperty
   a_reset_ign: assert property (p_reset_ign) else $error("left operation");

   property p_prog;
      q.st == ST_OPERATE && !q.sync[PIN_PROG]
         |=> q.st == ST_CLEAR ##1 q.st == ST_INIT && q.io_hiz == ioz_force;
   endproperty
   a_prog: assert property (p_prog) else $error("program ignored");

   property p_skip_clear;
      q.st == ST_CLEAR |=> q.mem_clear == !$past(q.opt.skip_clear);
   endproperty
   a_skip_clear: assert property (p_skip_clear) else $error("clear wrong");

endmodule

// File: core/fss_pkg.sv
package fss_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   localparam logic [7:0]  ADR_CTRL   = 8'h00;
   localparam logic [7:0]  ADR_LENGTH = 8'h04;
   localparam logic [7:0]  ADR_STATUS = 8'h08;

   // Start-up modes: bit 0 synchronized to done line, bit 1 user clock
   localparam logic [1:0]  CFGCLK_FREE_STARTUP    = 2'h0;
   localparam logic [1:0]  CFGCLK_SYNCED_STARTUP  = 2'h1;
   localparam logic [1:0]  USERCLK_FREE_STARTUP   = 2'h2;
   localparam logic [1:0]  USERCLK_SYNCED_STARTUP = 2'h3;

   // Control field positions
   localparam int          CT_MODE    = 0;
   localparam int          CT_PULLUP  = 2;
   localparam int          CT_DONE    = 3;
   localparam int          CT_FF      = 6;
   localparam int          CT_IO      = 9;
   localparam int          CT_SKIP    = 12;
   localparam int          CT_KEEP    = 13;
   localparam int          CT_NOGSR   = 14;
   localparam int          CT_NOIOZ   = 15;
   localparam int          CT_NORAM   = 16;

   localparam logic [31:0] CTRL_MASK  = 32'h0001_FFFF;
   localparam logic [31:0] LEN_MASK   = 32'h00FF_FFFF;
   localparam logic [31:0] CTRL_RST   = 32'h0000_000D;
   localparam logic [31:0] LEN_RST    = 32'h0000_0000;

   localparam logic [2:0]  MAX_DELAY  = 3'h4;
   localparam logic [1:0]  INIT_HIGH  = 2'h2;
   localparam logic [3:0]  CNT_SAT    = 4'hF;

   // Synchronised pin indices
   localparam int          PIN_CONFIG_CLOCK   = 0;
   localparam int          PIN_USER_STARTUP_CLOCK   = 1;
   localparam int          PIN_DONE   = 2;
   localparam int          PIN_INIT   = 3;
   localparam int          PIN_PROG   = 4;
   localparam int          PIN_RST    = 5;
   localparam int          NPIN       = 6;

   typedef enum logic [2:0] {ST_INIT, ST_CONFIG, ST_STARTUP, ST_OPERATE, ST_CLEAR} fss_state_e;

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } fss_wb_req_s;

   // Options captured by one configuration, applied to the next
   typedef struct packed {
      logic skip_clear;
      logic keep_running;
      logic no_gsr;
      logic no_ioz;
      logic no_ram_clear;
   } fss_opt_s;

endpackage

// File: verif/fss_partner.sv
`timescale 1ns/10ps
module fss_partner
(
   input  wire logic clk,
   input  wire logic done_out,
   input  wire logic done_oe,
   input  wire logic hold_low,
   output logic      config_clock,
   output logic      user_startup_clock,
   output logic      done_line
);
   // ------------------------------------------------------------
   // Wired done line and start-up clocks
   // ------------------------------------------------------------
   // Open drain: any sinking party wins, pull-up otherwise
   assign done_line = ~((done_oe & ~done_out) | hold_low);

   initial
   begin
      config_clock = 1'b0;
      user_startup_clock = 1'b0;
   end

   // Clocks stand still unless pulses are asked for
   task automatic pulses(input bit usr, input int n);
      for (int i = 0; i < n; i++)
      begin
         if (usr)
            user_startup_clock <= 1'b1;
         else
            config_clock <= 1'b1;
         repeat (3) @(posedge clk);
         user_startup_clock <= 1'b0;
         config_clock <= 1'b0;
         repeat (3) @(posedge clk);
      end
   endtask
endmodule

// File: verif/fss_sequencer_tb.sv
`timescale 1ns/10ps
module fss_sequencer_tb
   import fss_pkg::*;
;
   logic        clk;
   logic        resetn;
   fss_wb_req_s wb_req;
   logic        wb_ack;
   logic [31:0] wb_rdata;
   logic        config_clock, user_startup_clock, done_line, hold_low;
   logic        init_in, program_request_n, cfg_reset_n, eoc_frame_written;
   logic [3:0]  mode_sel;
   logic        done_out, done_oe, done_pullup_en, io_hiz, io_pullup_en;
   logic        logic_cell_hold, internal_bidir_hiz, comb_logic_live;
   logic        cfg_mem_clear, user_ram_clear, startup_done;
   int          n_fail;
   int          cmp_count;

   fss_sequencer fss_sequencer_inst (.clk(clk), .resetn(resetn), .wb_req(wb_req),
      .wb_ack(wb_ack), .wb_rdata(wb_rdata), .config_clock(config_clock),
      .user_startup_clock(user_startup_clock), .init_in(init_in),
      .program_request_n(program_request_n), .cfg_reset_n(cfg_reset_n),
      .mode_sel(mode_sel), .eoc_frame_written(eoc_frame_written), .done_in(done_line),
      .done_out(done_out), .done_oe(done_oe), .done_pullup_en(done_pullup_en),
      .io_hiz(io_hiz), .io_pullup_en(io_pullup_en), .logic_cell_hold(logic_cell_hold),
      .internal_bidir_hiz(internal_bidir_hiz), .comb_logic_live(comb_logic_live),
      .cfg_mem_clear(cfg_mem_clear), .user_ram_clear(user_ram_clear),
      .startup_done(startup_done));

   fss_partner fss_partner_inst (.clk(clk), .done_out(done_out), .done_oe(done_oe),
      .hold_low(hold_low), .config_clock(config_clock),
      .user_startup_clock(user_startup_clock), .done_line(done_line));

   always #50 clk = ~clk;

   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic tmo(input string nm);
      $display("CHECK FAILED %s exp done got pending", nm);
      n_fail++;
      end_of_test();
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e)
      begin
         n_fail++;
         $display("CHECK FAILED %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic chk_bit(input string nm, input logic e, input logic g);
      cmp_count++;
      if (g !== e)
      begin
         n_fail++;
         $display("CHECK FAILED %s exp %b got %b", nm, e, g);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // Classic single cycle; request held until ack is sampled
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv);
      int  n;
      logic ok;
      n = 0;
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: wd};
      do
      begin
         @(posedge clk);
         n++;
      end
      while (wb_ack !== 1'b1 && n < 20);
      ok = (wb_ack === 1'b1);
      rdv = wb_rdata;
      wb_req <= '0;
      @(posedge clk);
      if (!ok)
         tmo("bus ack");
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      logic [31:0] t;
      wb(1'b1, a, v, t);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      wb(1'b0, a, 32'h0, v);
   endtask

   task automatic chk_reg(input string nm, input logic [7:0] a, input logic [31:0] e);
      logic [31:0] v;
      rd(a, v);
      chk(nm, e, v);
   endtask

   task automatic wait_st(input logic [2:0] st);
      logic [31:0] d;
      for (int i = 0; i < 60; i++)
      begin
         rd(ADR_STATUS, d);
         if (d[2:0] === st)
            return;
      end
      tmo("state");
   endtask

   // Program pulse; catches the one-cycle clear strobes
   task automatic reprog(input logic eio, output logic mc, output logic rc);
      eoc_frame_written <= 1'b0;
      program_request_n <= 1'b0;
      mc = 1'b0;
      rc = 1'b0;
      for (int i = 0; i < 12; i++)
      begin
         @(posedge clk);
         mc = mc | (cfg_mem_clear === 1'b1);
         rc = rc | (user_ram_clear === 1'b1);
      end
      chk_bit("io float on program", eio, io_hiz);
      chk_bit("comb off", 1'b0, comb_logic_live);
      program_request_n <= 1'b1;
      wait_st(3'h1);
   endtask

   task automatic run_cfg();
      fss_partner_inst.pulses(1'b0, 6);
      eoc_frame_written <= 1'b1;
      wait_st(3'h2);
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      chk_reg("ctrl", ADR_CTRL, CTRL_RST);
      chk_reg("length", ADR_LENGTH, LEN_RST);
      chk_reg("status", ADR_STATUS, 32'h0);
      wr(ADR_LENGTH, 32'hFFFF_FFFF);
      chk_reg("length mask", ADR_LENGTH, LEN_MASK);
      wr(8'h0C, 32'hFFFF_FFFF);
      chk_reg("unmapped", 8'h0C, 32'h0);
      chk_bit("done pull-up", 1'b1, done_pullup_en);
      chk_bit("done sink", 1'b1, done_oe);
      chk_bit("io pull-up", 1'b1, io_pullup_en);
      chk_bit("done drive", 1'b0, done_out);
   endtask

   task automatic t_config();
      logic [31:0] d;
      init_in <= 1'b1;
      rd(ADR_STATUS, d);
      chk("early init", 32'h0, {29'h0, d[2:0]});
      wait_st(3'h1);
      chk_bit("comb live", 1'b1, comb_logic_live);
      chk_bit("io float", 1'b1, io_hiz);
      chk_bit("io pull-up", 1'b1, io_pullup_en);
      chk_bit("cell hold", 1'b1, logic_cell_hold);
      chk_bit("bidir float", 1'b1, internal_bidir_hiz);
      wr(ADR_LENGTH, 32'h6);
      fss_partner_inst.pulses(1'b0, 6);
      cyc(4);
      rd(ADR_STATUS, d);
      chk("no end frame", 32'h1, {29'h0, d[2:0]});
      eoc_frame_written <= 1'b1;
      wait_st(3'h2);
      chk_bit("done held", 1'b1, done_oe);
      hold_low <= 1'b1;
      fss_partner_inst.pulses(1'b0, 1);
      cyc(4);
      chk_bit("done first edge", 1'b0, done_oe);
      fss_partner_inst.pulses(1'b0, 4);
      cyc(4);
      chk_bit("held by line", 1'b1, logic_cell_hold);
      chk_bit("io held", 1'b1, io_hiz);
      hold_low <= 1'b0;
      fss_partner_inst.pulses(1'b0, 1);
      cyc(4);
      chk_bit("ff release", 1'b0, logic_cell_hold);
      chk_bit("io active", 1'b0, io_hiz);
      chk_bit("bidir live", 1'b0, internal_bidir_hiz);
      chk_bit("operate", 1'b1, startup_done);
   endtask

   task automatic t_reset_pin();
      cfg_reset_n <= 1'b0;
      cyc(10);
      chk_bit("reset ignored", 1'b1, startup_done);
      cfg_reset_n <= 1'b1;
      cyc(4);
   endtask

   task automatic t_free();
      logic        mc;
      logic        rc;
      logic [31:0] d;
      wr(ADR_CTRL, 32'h4 | (32'h1 << CT_DONE) | (32'h1 << CT_FF) | (32'h4 << CT_IO)
         | (32'h1 << CT_SKIP) | (32'h1 << CT_NORAM));
      mode_sel <= 4'hA;
      reprog(1'b1, mc, rc);
      chk_bit("mem clear", 1'b1, mc);
      chk_bit("ram clear", 1'b1, rc);
      rd(ADR_STATUS, d);
      chk("mode sampled", 32'hA, {28'h0, d[16:13]});
      run_cfg();
      hold_low <= 1'b1;
      fss_partner_inst.pulses(1'b0, 1);
      cyc(4);
      chk_bit("ff free", 1'b0, logic_cell_hold);
      chk_bit("done again", 1'b0, done_oe);
      fss_partner_inst.pulses(1'b0, 2);
      cyc(4);
      chk_bit("io delay", 1'b1, io_hiz);
      fss_partner_inst.pulses(1'b0, 1);
      cyc(4);
      chk_bit("io fourth", 1'b0, io_hiz);
      chk_bit("free operate", 1'b1, startup_done);
      hold_low <= 1'b0;
      rd(ADR_STATUS, d);
      chk("options", 32'h11, {27'h0, d[21:17]});
   endtask

   task automatic t_user();
      logic mc;
      logic rc;
      wr(ADR_CTRL, 32'h4 | (32'h1 << CT_DONE) | 32'(USERCLK_FREE_STARTUP));
      reprog(1'b1, mc, rc);
      chk_bit("skip clear", 1'b0, mc);
      chk_bit("skip ram", 1'b0, rc);
      run_cfg();
      fss_partner_inst.pulses(1'b0, 3);
      cyc(4);
      chk_bit("cfg clock unused", 1'b1, done_oe);
      fss_partner_inst.pulses(1'b1, 2);
      cyc(4);
      chk_bit("user done", 1'b0, done_oe);
      chk_bit("user operate", 1'b1, startup_done);
   endtask

   // Synced user clock, io after two edges, ff delay 7 clamps to 4
   task automatic t_opts();
      logic mc;
      logic rc;
      wr(ADR_CTRL, 32'h4 | (32'h1 << CT_DONE) | (32'h7 << CT_FF) | (32'h2 << CT_IO)
         | (32'h1 << CT_NOGSR) | (32'h1 << CT_NOIOZ) | 32'(USERCLK_SYNCED_STARTUP));
      reprog(1'b1, mc, rc);
      run_cfg();
      fss_partner_inst.pulses(1'b1, 1);
      cyc(4);
      chk_bit("user sync done", 1'b0, done_oe);
      fss_partner_inst.pulses(1'b1, 3);
      cyc(4);
      chk_bit("io second edge", 1'b0, io_hiz);
      chk_bit("ff clamped", 1'b1, logic_cell_hold);
      fss_partner_inst.pulses(1'b1, 1);
      cyc(4);
      chk_bit("ff third", 1'b1, logic_cell_hold);
      fss_partner_inst.pulses(1'b1, 1);
      cyc(4);
      chk_bit("ff fourth", 1'b0, logic_cell_hold);
      chk_bit("sync operate", 1'b1, startup_done);
      reprog(1'b0, mc, rc);
      chk_bit("clear again", 1'b1, mc);
      chk_bit("no gsr", 1'b0, logic_cell_hold);
      chk_bit("no io float", 1'b0, io_hiz);
   endtask

   initial
   begin
      clk = 1'b0;
      resetn = 1'b0;
      wb_req = '0;
      init_in = 1'b0;
      program_request_n = 1'b1;
      cfg_reset_n = 1'b1;
      mode_sel = 4'h0;
      eoc_frame_written = 1'b0;
      hold_low = 1'b0;
      n_fail = 0;
      cmp_count = 0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      cyc(6);
      t_reset();
      t_config();
      t_reset_pin();
      t_free();
      t_user();
      t_opts();
      end_of_test();
   end
endmodule
